// File: inc/pullup_pkg.sv
// package: register map, masks and bus carriers for the pull-up block
`default_nettype none
package pullup_pkg;
  localparam int ADDR_W = 12;
  localparam int NUM_REGS = 5;
  // printed offsets are not all multiples of four: they are indexes
  localparam logic [7:0] IDX_PORT0 = 8'he0;
  localparam logic [7:0] IDX_PORT1 = 8'he1;
  localparam logic [7:0] IDX_PORT2 = 8'he2;
  localparam logic [7:0] IDX_PORT4 = 8'he4;
  localparam logic [7:0] IDX_PORT5 = 8'he5;
  // implemented (writable) bits per register
  localparam logic [7:0] MASK_PORT0 = 8'h07;
  localparam logic [7:0] MASK_PORT1 = 8'h01;
  localparam logic [7:0] MASK_PORT2 = 8'hff;
  localparam logic [7:0] MASK_PORT4 = 8'hff;
  localparam logic [7:0] MASK_PORT5 = 8'h18;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam int PIN_THREE_BIT = 3;
  localparam logic [7:0] PORT0_FIXED_ONES = 8'h08;
  localparam logic [31:0] READ_VALUE = 32'h0000_0000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [7:0] port0;
    logic [7:0] port1;
    logic [7:0] port2;
    logic [7:0] port4;
    logic [7:0] port5;
  } pullup_bank_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction
endpackage
`default_nettype wire

// File: hdl/enable_reg.sv
// one write-only pull-up enable register with per-bit implementation mask
`timescale 1ns/1ps
`default_nettype none
module enable_reg
  import pullup_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff,
  parameter logic [7:0] FIXED = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  logic [7:0] bits_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bits_r <= ENABLE_RESET;
    end else if (wr_en) begin
      bits_r <= wdata & MASK;
    end
  end

  // fixed bits are constants, so writes never reach them
  assign q = bits_r | FIXED;
endmodule
`default_nettype wire

// File: hdl/port_pullup_control.sv
// apb slave holding the write-only pull-up enables of ports 0,1,2,4,5
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module port_pullup_control
  import pullup_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] port0_pullup_on,
  output logic [7:0] port1_pullup_on,
  output logic [7:0] port2_pullup_on,
  output logic [7:0] port4_pullup_on,
  output logic [7:0] port5_pullup_on
);
  // phase of the slave: one answer cycle follows every setup cycle
  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_ANSWER = 1'b1
  } phase_t;

  apb_req_t req;
  pullup_bank_t bank;
  phase_t phase_r;
  phase_t phase_nxt;
  logic setup;
  logic access;
  logic hit;
  logic wr_lane;
  logic commit;
  logic [NUM_REGS-1:0] wsel;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [7:0] pad0_r;
  logic [7:0] pad1_r;
  logic [7:0] pad2_r;
  logic [7:0] pad4_r;
  logic [7:0] pad5_r;

  // one-hot register select from a byte address; zero when unmapped
  function automatic logic [NUM_REGS-1:0] reg_select(
    input logic [ADDR_W-1:0] addr
  );
    logic [NUM_REGS-1:0] sel;
    sel = '0;
    unique case (addr)
      byte_addr(IDX_PORT0): sel[0] = 1'b1;
      byte_addr(IDX_PORT1): sel[1] = 1'b1;
      byte_addr(IDX_PORT2): sel[2] = 1'b1;
      byte_addr(IDX_PORT4): sel[3] = 1'b1;
      byte_addr(IDX_PORT5): sel[4] = 1'b1;
      default: sel = '0;
    endcase
    return sel;
  endfunction

  // only bits with a pin and a resistor behind them reach a pad
  function automatic logic [7:0] pin_drive(
    input logic [7:0] enables,
    input logic [7:0] pinned
  );
    return enables & pinned;
  endfunction

  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};
  assign setup = req.psel && !req.penable;
  assign access = req.psel && req.penable;
  assign wr_lane = pstrb[0];
  assign wsel = reg_select(req.paddr);
  assign hit = |wsel;

  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      PH_IDLE: begin
        if (setup) begin
          phase_nxt = PH_ANSWER;
        end
      end
      PH_ANSWER: begin
        // access lasts one cycle; a new setup may follow at once
        phase_nxt = setup ? PH_ANSWER : PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // no wait state: answer in the cycle after setup, writes land then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= (phase_nxt == PH_ANSWER);
      pslverr_r <= (phase_nxt == PH_ANSWER) && !hit;
    end
  end

  // a write without lane 0 carries no enable byte, so it is dropped
  assign commit = access && (phase_r == PH_ANSWER) && req.pwrite
                  && wr_lane;

  enable_reg #(
    .MASK(MASK_PORT0),
    .FIXED(PORT0_FIXED_ONES)
  ) u_p0 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(commit && wsel[0]),
    .wdata(req.pwdata[7:0]),
    .q(bank.port0)
  );

  enable_reg #(
    .MASK(MASK_PORT1),
    .FIXED(ENABLE_RESET)
  ) u_p1 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(commit && wsel[1]),
    .wdata(req.pwdata[7:0]),
    .q(bank.port1)
  );

  enable_reg #(
    .MASK(MASK_PORT2),
    .FIXED(ENABLE_RESET)
  ) u_p2 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(commit && wsel[2]),
    .wdata(req.pwdata[7:0]),
    .q(bank.port2)
  );

  enable_reg #(
    .MASK(MASK_PORT4),
    .FIXED(ENABLE_RESET)
  ) u_p4 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(commit && wsel[3]),
    .wdata(req.pwdata[7:0]),
    .q(bank.port4)
  );

  enable_reg #(
    .MASK(MASK_PORT5),
    .FIXED(ENABLE_RESET)
  ) u_p5 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(commit && wsel[4]),
    .wdata(req.pwdata[7:0]),
    .q(bank.port5)
  );

  // pin three of port 0 is input-only: its fixed one never reaches a pad
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad0_r <= ENABLE_RESET;
    end else begin
      pad0_r <= pin_drive(bank.port0, MASK_PORT0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad1_r <= ENABLE_RESET;
    end else begin
      pad1_r <= pin_drive(bank.port1, MASK_PORT1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad2_r <= ENABLE_RESET;
    end else begin
      pad2_r <= pin_drive(bank.port2, MASK_PORT2);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad4_r <= ENABLE_RESET;
    end else begin
      pad4_r <= pin_drive(bank.port4, MASK_PORT4);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad5_r <= ENABLE_RESET;
    end else begin
      pad5_r <= pin_drive(bank.port5, MASK_PORT5);
    end
  end

  // write-only: nothing stored is ever routed to the read bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= READ_VALUE;
    end else begin
      prdata_r <= READ_VALUE;
    end
  end

  assign port0_pullup_on = pad0_r;
  assign port1_pullup_on = pad1_r;
  assign port2_pullup_on = pad2_r;
  assign port4_pullup_on = pad4_r;
  assign port5_pullup_on = pad5_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
endmodule
`default_nettype wire

// File: test/pullup_asserts.sv
// port assertions for the pull-up enable block
`timescale 1ns/1ps
`default_nettype none
module pullup_asserts
  import pullup_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] port0_pullup_on,
  input wire logic [7:0] port1_pullup_on,
  input wire logic [7:0] port2_pullup_on,
  input wire logic [7:0] port4_pullup_on,
  input wire logic [7:0] port5_pullup_on
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr2;
    psel && penable && pready && pwrite && pstrb[0]
      && paddr == byte_addr(IDX_PORT2);
  endsequence
  property p_wr;
    s_setup ##1 s_wr2 |-> ##2 port2_pullup_on == $past(pwdata[7:0], 2);
  endproperty
  property p_rdy;
    s_setup |=> pready;
  endproperty
  property p_rdy_once;
    pready |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_rd;
    prdata == READ_VALUE;
  endproperty
  property p_rst;
    $rose(presetn) |-> !pready && !pslverr
      && port0_pullup_on == ENABLE_RESET && port1_pullup_on == ENABLE_RESET
      && port2_pullup_on == ENABLE_RESET && port4_pullup_on == ENABLE_RESET
      && port5_pullup_on == ENABLE_RESET;
  endproperty
  property p_pin3;
    !port0_pullup_on[3];
  endproperty
  property p_unimpl;
    port0_pullup_on[7:4] == 4'h0 && port1_pullup_on[7:1] == 7'h0
      && (port5_pullup_on & 8'he7) == 8'h0;
  endproperty
  a_wr: assert property (p_wr) else $error("pull-up not set");
  a_rdy: assert property (p_rdy) else $error("no ready");
  a_rdy_once: assert property (p_rdy_once) else $error("ready held");
  a_err: assert property (p_err) else $error("error alone");
  a_rd: assert property (p_rd) else $error("read not zero");
  a_rst: assert property (p_rst) else $error("reset value");
  a_pin3: assert property (p_pin3) else $error("pin 3 on");
  a_unimpl: assert property (p_unimpl) else $error("bit on");
endmodule
`default_nettype wire

// File: test/tb.sv
// bench for the pull-up enable block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pullup_pkg::*;
  logic pclk = 0, psel = 0, penable = 0, pwrite = 0, presetn, pslverr;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, err;
  pullup_bank_t pins;
  int n_errors = 0, comparisons = 0;
  logic [7:0] idx [5] = '{IDX_PORT0, IDX_PORT1, IDX_PORT2, IDX_PORT4,
    IDX_PORT5};
  always #20 pclk = ~pclk;
  port_pullup_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port0_pullup_on(pins.port0), .port1_pullup_on(pins.port1),
    .port2_pullup_on(pins.port2), .port4_pullup_on(pins.port4),
    .port5_pullup_on(pins.port5));
  task automatic conclude();
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // pads expected after writing p to every register
  function automatic pullup_bank_t expect_bank(input logic [7:0] p);
    return {MASK_PORT0 & 8'hf7 & p, MASK_PORT1 & p, MASK_PORT2 & p,
      MASK_PORT4 & p, MASK_PORT5 & p};
  endfunction
  // upper data bits set on purpose: they must be ignored
  task automatic apb(input logic [7:0] i, input logic w, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= ADDR_W'({i, 2'b00});
    pwdata <= {24'hffffff, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: no pready", $time);
      conclude();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      repeat (3) @(posedge pclk);
    end
  endtask
  task automatic t_write(input logic [7:0] p);
    for (int k = 0; k < 5; k++) apb(idx[k], 1, p);
    chk(pins, expect_bank(p));
  endtask
  // reads follow writes of ones, so a leaking register would show
  task automatic t_read();
    for (int k = 0; k < 5; k++) begin
      apb(idx[k], 1, 8'hff);
      apb(idx[k], 0, 8'h00);
      chk({err, rd}, {1'b0, 32'h0});
    end
    chk(pins, expect_bank(8'hff));
    apb(8'he3, 1, 8'h00);
    chk({err, pins}, {1'b1, expect_bank(8'hff)});
    t_write(8'h00);
  endtask
  task automatic t_strb();
    pstrb <= 4'he;
    apb(IDX_PORT2, 1, 8'hff);
    pstrb <= 4'hf;
    chk({err, pins}, 48'h0);
  endtask
  task automatic t_reset();
    t_write(8'hff);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({pready, pins}, 48'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({pready, pslverr, pins}, 48'h0);
    t_write(8'h5a);
  endtask
  initial begin
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({pready, pslverr, pins}, 48'h0);
    t_write(8'hff);
    t_write(8'h5a);
    t_write(8'h00);
    t_read();
    t_strb();
    t_reset();
    conclude();
  end
endmodule
bind port_pullup_control pullup_asserts u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .port0_pullup_on(port0_pullup_on),
  .port1_pullup_on(port1_pullup_on),
  .port2_pullup_on(port2_pullup_on),
  .port4_pullup_on(port4_pullup_on),
  .port5_pullup_on(port5_pullup_on)
);
`default_nettype wire
